// ### logic/overvoltage_protection_stage.sv
`timescale 1ns/100ps
// What this block does
// RULE1 - uses only fundamental line-to-line magnitudes
// RULE2 - start when any voltage exceeds threshold
// RULE3 - trip after start persists past delay
// RULE4 - three independent definite-time stages
// RULE5 - low stage counter held for release delay
// RULE6 - reappearing fault resumes held counter
// RULE7 - fault holds until below release level
// RULE8 - hysteresis 0.1 to 20.0 percent
// RULE9 - hysteresis must stay below voltage margin; not enforced, hysteresis is only clamped to 0.1 to 20.0 percent
// RULE10 - low stage threshold and delay ranges
// RULE11 - high stage threshold and delay ranges
// RULE12 - highest stage threshold and delay ranges
// RULE13 - four setting groups per stage
// RULE14 - zero delay only when explicitly accepted
// RULE15 - blocking clears start, trip and counter
// RULE16 - events on start and trip edges
module overvoltage_protection_stage
#(
    parameter int TICK_CYCLES = ovp_pkg::TICK_CYCLES // cycles per 10 ms
)
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clk_en,      // low freezes all state
    // fundamental magnitudes in 0.1 % of nominal, same clock
    input  wire logic [15:0] volt_ab,
    input  wire logic [15:0] volt_bc,
    input  wire logic [15:0] volt_ca,
    input  wire logic [2:0]  block_in,    // per-stage blocking pins
    output logic      [2:0]  start,       // low, high, highest
    output logic      [2:0]  trip,
    output logic             irq,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ========================================================
    // declarations
    // ========================================================
    logic [31:0]  ctrl;                   // group, accept zero, ev en
    logic [11:0]  evt;                    // sticky events
    logic [11:0]  mask;                   // interrupt mask
    logic [11:0]  evt_set;                // events raised this cycle
    logic         ack;                    // apb wait state done
    logic         wr_go;                  // write takes effect
    logic [31:0]  mem_rd;                 // registered setting read
    logic [31:0]  act_word [6];           // active group words
    logic [2:0]   blk_meta;               // sync stage one
    logic [2:0]   blk;                    // synchronised block
    logic [18:0]  presc;                  // tick prescaler
    logic         tick;                   // one 10 ms pulse
    logic [2:0]   over;                   // above start level
    logic [2:0]   hold;                   // above release level
    logic [2:0]   fault;                  // stage fault state
    logic [14:0]  cnt     [3];            // operate counter
    logic [14:0]  rel_cnt;                // low stage release counter
    logic [7:0]   thr     [3];            // clamped threshold
    logic [7:0]   hyst    [3];            // clamped hysteresis
    logic [14:0]  op_dly  [3];            // effective operate delay
    logic [14:0]  rel_dly;                // effective release delay
    logic [2:0]   next_fault;
    logic [2:0]   next_trip;

    // ========================================================
    // helpers
    // ========================================================
    // voltage above thr scaled by ratio/1000 (ratio in 0.1 %)
    function automatic logic above(input logic [15:0] v,
                                   input logic [7:0]  t,
                                   input logic [9:0]  ratio,
                                   input logic        strict);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(v) * 24'd100;
        rhs = 24'(t) * 24'(ratio);
        return strict ? (lhs > rhs) : (lhs >= rhs);
    endfunction : above

    // clamp a value into a range
    function automatic logic [14:0] clamp(input logic [14:0] v,
                                          input logic [14:0] lo,
                                          input logic [14:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : clamp

    // ========================================================
    // blocking pins cross in from outside: two flops
    // ========================================================
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            blk_meta <= 3'h0;
            blk      <= 3'h0;
        end
        else if (clk_en)
        begin
            blk_meta <= block_in;
            blk      <= blk_meta;
        end
    end

    // ========================================================
    // 10 ms tick; delays count ticks, not cycles
    // ========================================================
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            presc <= 19'h00000;
        else if (clk_en)
            presc <= (presc == 19'(TICK_CYCLES - 1)) ? 19'h00000
                                                     : presc + 19'h00001;
    end
    assign tick = clk_en && presc == 19'(TICK_CYCLES - 1);

    // ========================================================
    // active settings, clamped to each stage's legal range
    // ========================================================
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            // group word picked by the memory [RULE13]
            thr[i] = 8'(clamp(15'(act_word[2*i][ovp_pkg::SW_THR +: 8]),
                        15'(ovp_pkg::THR_MIN),
                        15'(i == 2 ? ovp_pkg::THR_MAX_TOP
                                   : ovp_pkg::THR_MAX_LOW))); // [RULE10]
            hyst[i] = 8'(clamp(15'(act_word[2*i][ovp_pkg::SW_HYST +: 8]),
                         15'(ovp_pkg::HYST_MIN),
                         15'(ovp_pkg::HYST_MAX)));           // [RULE8]
            op_dly[i] = act_word[2*i+1][ovp_pkg::SW_OP +: 15];
            // 20 ms step on the two slower stages [RULE11]
            if (i != 2)
                op_dly[i][0] = 1'b0;
            if (op_dly[i] == 15'h0000 && ctrl[ovp_pkg::CTRL_ACCZ])
                op_dly[i] = 15'h0000;                        // [RULE14]
            else
                op_dly[i] = clamp(op_dly[i],
                    i == 0 ? ovp_pkg::OP_MIN_LOW :
                    i == 1 ? ovp_pkg::OP_MIN_HIGH :
                             ovp_pkg::OP_MIN_TOP,
                    ovp_pkg::DLY_MAX);                       // [RULE12]
        end
        // lowest field bit dropped: release moves in 20 ms steps
        rel_dly = clamp({act_word[1][ovp_pkg::SW_REL + 1 +: 14], 1'b0},
                        ovp_pkg::REL_MIN, ovp_pkg::DLY_MAX); // [RULE5]
    end

    // ========================================================
    // level comparison on line-to-line magnitudes only [RULE1]
    // ========================================================
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            // start level is thr * 100 %, strictly above [RULE2]
            over[i] = above(volt_ab, thr[i], 10'd1000, 1'b1) ||
                      above(volt_bc, thr[i], 10'd1000, 1'b1) ||
                      above(volt_ca, thr[i], 10'd1000, 1'b1);
            // release level thr * (1 - hyst); a hysteresis wider
            // than the voltage margin never releases [RULE7] [RULE9]
            hold[i] = above(volt_ab, thr[i], 10'd1000 - 10'(hyst[i]), 1'b0)
                   || above(volt_bc, thr[i], 10'd1000 - 10'(hyst[i]), 1'b0)
                   || above(volt_ca, thr[i], 10'd1000 - 10'(hyst[i]), 1'b0);
            next_fault[i] = !blk[i] &&
                            (over[i] || (fault[i] && hold[i]));  // [RULE15]
            next_trip[i]  = next_fault[i] && cnt[i] >= op_dly[i]; // [RULE3]
        end
    end

    // ========================================================
    // stage state, three independent definite-time stages [RULE4]
    // ========================================================
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            fault <= 3'h0;
            start <= 3'h0;
            trip  <= 3'h0;
        end
        else if (clk_en)
        begin
            fault <= next_fault;
            start <= next_fault;                         // [RULE2]
            trip  <= next_trip;                          // [RULE3]
        end
    end

    // operate counters; only the low stage keeps its count
    // through a short gap, so intermittent faults add up
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            for (int i = 0; i < 3; i++)
                cnt[i] <= 15'h0000;
            rel_cnt <= 15'h0000;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (blk[i])
                    cnt[i] <= 15'h0000;                  // [RULE15]
                else if (fault[i])
                begin
                    // resumes from the held value [RULE6]
                    if (tick && cnt[i] < ovp_pkg::DLY_MAX)
                        cnt[i] <= cnt[i] + 15'h0001;
                end
                else if (i != 0 || rel_cnt >= rel_dly)
                    cnt[i] <= 15'h0000;                  // [RULE5]
            end
            if (blk[0] || fault[0])
                rel_cnt <= 15'h0000;
            else if (tick && rel_cnt < ovp_pkg::DLY_MAX)
                rel_cnt <= rel_cnt + 15'h0001;           // [RULE5]
        end
    end

    // ========================================================
    // events: edges of start and trip, per-stage enable
    // ========================================================
    always_comb
    begin
        evt_set = 12'h000;
        for (int i = 0; i < 3; i++)
            if (ctrl[ovp_pkg::CTRL_EVEN + i])
            begin
                evt_set[ovp_pkg::EV_START_ON  + i] = next_fault[i] & ~start[i];
                evt_set[ovp_pkg::EV_START_OFF + i] = ~next_fault[i] & start[i];
                evt_set[ovp_pkg::EV_TRIP_ON   + i] = next_trip[i] & ~trip[i];
                evt_set[ovp_pkg::EV_TRIP_OFF  + i] = ~next_trip[i] & trip[i];
            end                                          // [RULE16]
    end

    // sticky bits; a new event beats a write-one clear
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            evt <= 12'h000;
        else if (clk_en)
            evt <= (evt & ~((wr_go && paddr == ovp_pkg::OFS_EVENT)
                            ? pwdata[11:0] : 12'h000)) | evt_set;
    end

    assign irq = |(evt & mask);

    // ========================================================
    // apb slave: one wait state so settings reads are registered
    // ========================================================
    assign wr_go  = psel && penable && ack && pwrite;
    assign pready = penable && ack;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            ack <= 1'b0;
        else if (clk_en)
            ack <= psel && penable && !ack;
    end

    // control and mask registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrl <= ovp_pkg::CTRL_RESET;
            mask <= 12'h000;
        end
        else if (clk_en && wr_go)
        begin
            if (paddr == ovp_pkg::OFS_CTRL)
                ctrl <= {26'h0000000, pwdata[5:0]};
            if (paddr == ovp_pkg::OFS_MASK)
                mask <= pwdata[11:0];
        end
    end

    // read data and error captured in the first access cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clk_en && psel && penable && !ack)
        begin
            pslverr <= 1'b0;
            case (paddr)
                ovp_pkg::OFS_CTRL:   prdata <= ctrl;
                ovp_pkg::OFS_STATUS: prdata <= {26'h0, trip, start};
                ovp_pkg::OFS_EVENT:  prdata <= {20'h0, evt};
                ovp_pkg::OFS_MASK:   prdata <= {20'h0, mask};
                default:
                begin
                    // setting window or unmapped
                    if (paddr >= ovp_pkg::OFS_SET_LO &&
                        paddr <= ovp_pkg::OFS_SET_HI && paddr[1:0] == 2'h0)
                        prdata <= mem_rd;
                    else
                    begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                end
            endcase
        end
    end

    // setting memory with group select [RULE13]
    ovp_setting_mem u_mem
    (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .clk_en   (clk_en),
        .wr_en    (wr_go && paddr >= ovp_pkg::OFS_SET_LO &&
                   paddr <= ovp_pkg::OFS_SET_HI && paddr[1:0] == 2'h0),
        .wr_idx   (5'((paddr - ovp_pkg::OFS_SET_LO) >> 2)),
        .wr_data  (pwdata),
        .rd_idx   (5'((paddr - ovp_pkg::OFS_SET_LO) >> 2)),
        .rd_data  (mem_rd),
        .group    (ctrl[ovp_pkg::CTRL_GRP +: 2]),
        .act_word (act_word)
    );

    // ========================================================
    // assertions
    // ========================================================
    for (genvar g = 0; g < 3; g++)
    begin : g_chk
        a_start_cause: assert property (@(posedge clk_sys) disable iff (reset)
            $rose(start[g]) |-> $past(over[g])) // [RULE2]
            else $error("start rose without overvoltage");
        a_start_follow: assert property (@(posedge clk_sys)
            disable iff (reset)
            clk_en && over[g] && !blk[g] |=> start[g]) // [RULE2]
            else $error("start missed overvoltage");
        a_trip_time: assert property (@(posedge clk_sys) disable iff (reset)
            $rose(trip[g]) |-> $past(cnt[g] >= op_dly[g])) // [RULE3]
            else $error("trip before operate delay");
        a_trip_start: assert property (@(posedge clk_sys) disable iff (reset)
            trip[g] |-> start[g]) // [RULE3]
            else $error("trip without start");
        a_block_clear: assert property (@(posedge clk_sys)
            disable iff (reset)
            clk_en && blk[g] |=> !start[g] && !trip[g] && cnt[g] == 15'h0)
            // [RULE15]
            else $error("blocking did not clear stage");
        a_hyst_hold: assert property (@(posedge clk_sys) disable iff (reset)
            clk_en && fault[g] && hold[g] && !blk[g] |=> start[g]) // [RULE7]
            else $error("released above release level");
        a_zero_delay: assert property (@(posedge clk_sys)
            disable iff (reset)
            !ctrl[ovp_pkg::CTRL_ACCZ] |-> op_dly[g] >= ovp_pkg::OP_MIN_TOP)
            // [RULE14]
            else $error("zero delay without acceptance");
        if (g != 0)
        begin : g_fast
            a_upper_reset: assert property (@(posedge clk_sys)
                disable iff (reset)
                clk_en && !fault[g] |=> cnt[g] == 15'h0) // [RULE4]
                else $error("upper stage counter kept");
        end
    end

    a_low_held: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && !fault[0] && !blk[0] && rel_cnt < rel_dly
        |=> cnt[0] == $past(cnt[0])) // [RULE5]
        else $error("low stage counter lost in release");
    a_irq_level: assert property (@(posedge clk_sys) // [RULE16]
        disable iff (reset)
        clk_en && !wr_go && |(evt_set & mask) |=> irq)
        else $error("event not raised to irq");

endmodule : overvoltage_protection_stage

// ### logic/ovp_pkg.sv
// ============================================================
// constants shared by the overvoltage stage block
// ============================================================
package ovp_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int          CLK_HZ      = 40_000_000; // clk_sys rate
    localparam int          TICK_MS     = 10;         // delay resolution
    // cycles per delay tick, derived from the rate
    localparam int          TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [14:0] DLY_MAX     = 15'h7530;   // 300.00 s in ticks
    localparam logic [14:0] OP_MIN_LOW  = 15'h0008;   // 0.08 s
    localparam logic [14:0] OP_MIN_HIGH = 15'h0006;   // 0.06 s
    localparam logic [14:0] OP_MIN_TOP  = 15'h0004;   // 0.04 s
    localparam logic [14:0] REL_MIN     = 15'h0006;   // 0.06 s

    // ==========================================================
    // setting ranges (threshold in % of nominal, hyst in 0.1 %)
    // ==========================================================
    localparam logic [7:0]  THR_MIN      = 8'h32;     // 50 %
    localparam logic [7:0]  THR_MAX_LOW  = 8'h96;     // 150 %
    localparam logic [7:0]  THR_MAX_TOP  = 8'ha0;     // 160 %
    localparam logic [7:0]  HYST_MIN     = 8'h01;     // 0.1 %
    localparam logic [7:0]  HYST_MAX     = 8'hc8;     // 20.0 %

    // ==========================================================
    // apb register map (byte addresses)
    // ==========================================================
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_EVENT   = 8'h08;
    localparam logic [7:0]  OFS_MASK    = 8'h0c;
    localparam logic [7:0]  OFS_SET_LO  = 8'h40;      // first setting word
    localparam logic [7:0]  OFS_SET_HI  = 8'h9c;      // last setting word

    // ctrl fields
    localparam int          CTRL_GRP    = 0;          // [1:0] active group
    localparam int          CTRL_ACCZ   = 2;          // accept zero delay
    localparam int          CTRL_EVEN   = 3;          // [5:3] event enables
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0038;

    // event bit groups, three bits each (one per stage)
    localparam int          EV_START_ON  = 0;
    localparam int          EV_START_OFF = 3;
    localparam int          EV_TRIP_ON   = 6;
    localparam int          EV_TRIP_OFF  = 9;
    localparam int          EV_BITS      = 12;

    // setting word layout: word 0 thr/hyst, word 1 op/release
    localparam int          SW_THR      = 0;          // [7:0]
    localparam int          SW_HYST     = 8;          // [15:8]
    localparam int          SW_OP       = 0;          // [14:0]
    localparam int          SW_REL      = 16;         // [30:16]
    localparam logic [31:0] SW0_RESET   = 32'h0000_1e6e; // 110 %, 3.0 %
    localparam logic [31:0] SW1_RESET   = 32'h0006_0032; // 0.50 s, 0.06 s

    localparam int          STAGES      = 3;
    localparam int          GROUPS      = 4;
    localparam int          SET_WORDS   = STAGES * GROUPS * 2;

endpackage : ovp_pkg

// ### logic/ovp_setting_mem.sv
`timescale 1ns/100ps
// ============================================================
// setting storage: all groups of all stages, registered reads
// ============================================================
module ovp_setting_mem
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        wr_en,        // write strobe
    input  wire logic [4:0]  wr_idx,       // word index
    input  wire logic [31:0] wr_data,
    input  wire logic [4:0]  rd_idx,       // bus read index
    output logic      [31:0] rd_data,      // registered bus read
    input  wire logic [1:0]  group,        // active setting group
    output logic      [31:0] act_word [6]  // active words, stage*2+w
);

    logic [31:0] mem [ovp_pkg::SET_WORDS];  // stage*8 + group*2 + w

    // ========================================================
    // write port; reset loads sane defaults so stages never
    // run on undefined thresholds
    // ========================================================
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            for (int i = 0; i < ovp_pkg::SET_WORDS; i++)
                mem[i] <= (i % 2 == 0) ? ovp_pkg::SW0_RESET
                                       : ovp_pkg::SW1_RESET;
        end
        else if (clk_en && wr_en && wr_idx < 5'(ovp_pkg::SET_WORDS))
            mem[wr_idx] <= wr_data;
    end

    // ========================================================
    // read ports; the active group takes effect one cycle late
    // ========================================================
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rd_data <= 32'h0000_0000;
            for (int k = 0; k < 6; k++)
                act_word[k] <= (k % 2 == 0) ? ovp_pkg::SW0_RESET
                                            : ovp_pkg::SW1_RESET;
        end
        else if (clk_en)
        begin
            // out of range index reads zero
            rd_data <= (rd_idx < 5'(ovp_pkg::SET_WORDS)) ? mem[rd_idx]
                                                         : 32'h0000_0000;
            for (int k = 0; k < 6; k++)
                act_word[k] <= mem[(k / 2) * 8 + 32'(group) * 2 + k % 2];
        end
    end

endmodule : ovp_setting_mem

// ### tb/meas_front_end.sv
`timescale 1ns/100ps
// ============================================================
// front end model: fundamental line-to-line magnitudes
// ============================================================
module meas_front_end
(
    input  wire logic        clk_sys,
    input  wire logic [15:0] level,    // magnitude for the chosen pair
    input  wire logic [1:0]  pair,     // 0 ab, 1 bc, 2 ca
    output logic      [15:0] volt_ab,
    output logic      [15:0] volt_bc,
    output logic      [15:0] volt_ca
);
    // unchosen pairs sit at nominal; only l-l values leave here
    // nominal stays inside every stage's hysteresis margin
    always_ff @(posedge clk_sys)
    begin
        volt_ab <= (pair == 2'h0) ? level : 16'h03e8;
        volt_bc <= (pair == 2'h1) ? level : 16'h03e8;
        volt_ca <= (pair == 2'h2) ? level : 16'h03e8;
    end
endmodule : meas_front_end

// ### tb/overvoltage_protection_stage_tb.sv
`timescale 1ns/100ps
module overvoltage_protection_stage_tb;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic [15:0] level   = 16'h03e8;
    logic [1:0]  pair    = 2'h0;
    logic [2:0]  block_in = 3'h0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] volt_ab, volt_bc, volt_ca;
    logic [2:0]  start, trip;
    logic        irq, pready, pslverr;
    int          n_errors = 0, compares = 0, k;
    typedef struct { logic [15:0] v; logic [1:0] p; logic [2:0] s; } row_t;
    // level, pair, start; 1067 still held by the 3 % dead band
    row_t rows [6] = '{'{16'h044c, 2'h0, 3'h0}, '{16'h044d, 2'h1, 3'h7},
        '{16'h042b, 2'h2, 3'h7}, '{16'h042a, 2'h2, 3'h0},
        '{16'h044d, 2'h2, 3'h7}, '{16'h03e8, 2'h0, 3'h0}};
    always #12.5 clk_sys = ~clk_sys;
    meas_front_end FE (.clk_sys(clk_sys), .level(level), .pair(pair),
        .volt_ab(volt_ab), .volt_bc(volt_bc), .volt_ca(volt_ca));
    // short tick keeps 0.50 s at 200 cycles
    overvoltage_protection_stage #(.TICK_CYCLES(4)) DUT (.clk_sys(clk_sys),
        .reset(reset), .clk_en(1'b1), .volt_ab(volt_ab), .volt_bc(volt_bc),
        .volt_ca(volt_ca), .block_in(block_in), .start(start), .trip(trip),
        .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic check(input string name, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        check("apb_wait", pready, 1'b1);
        if (pready !== 1'b1) summarize();
    endtask : apb
    // hold a level on one pair for n cycles
    task automatic drive(input logic [15:0] v, input int n);
        @(posedge clk_sys);
        level <= v; pair <= 2'h1;
        repeat (n) @(posedge clk_sys);
    endtask : drive
    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        check("start_rst", {start, trip, irq}, 32'h0);
        apb(1'b0, ovp_pkg::OFS_CTRL, 32'h0);
        check("ctrl_rst", rd, ovp_pkg::CTRL_RESET);
        foreach (rows[i])
        begin
            @(posedge clk_sys);
            level <= rows[i].v; pair <= rows[i].p;
            repeat (4) @(posedge clk_sys);
            check("start_row", start, rows[i].s);
        end
        repeat (40) @(posedge clk_sys);
        @(posedge clk_sys);
        level <= 16'h044d;
        k = 0;
        while (trip !== 3'h7 && k < 400)
        begin
            @(posedge clk_sys);
            k++;
        end
        check("trip_time", 32'(k >= 198 && k <= 214), 32'h1);
        block_in <= 3'h7;
        repeat (4) @(posedge clk_sys);
        check("blocked", {start, trip}, 6'h0);
        block_in <= 3'h0;
        drive(16'h03e8, 40);
        apb(1'b1, ovp_pkg::OFS_MASK, 32'h7);
        @(posedge clk_sys);
        check("irq_on", irq, 1'b1);
        apb(1'b1, ovp_pkg::OFS_EVENT, 32'hfff);
        @(posedge clk_sys);
        check("irq_off", irq, 1'b0);
        drive(16'h044d, 120);
        drive(16'h03e8, 8);
        drive(16'h044d, 100);
        check("resume", trip, 3'h1);
        // group 1 of the low stage: 100 %, 1.0 %, zero operate delay
        drive(16'h041a, 40);
        apb(1'b1, 8'h48, 32'h0000_0a64);
        apb(1'b1, 8'h4c, 32'h0006_0000);
        apb(1'b0, 8'h48, 32'h0);
        check("set_rd", rd, 32'h0000_0a64);
        apb(1'b1, ovp_pkg::OFS_CTRL, 32'h3d);
        repeat (4) @(posedge clk_sys);
        check("group", {trip, start}, 6'h09);
        apb(1'b0, 8'ha0, 32'h0);
        check("unmapped_err", last_err, 1'b1);
        check("unmapped_rd", rd, 32'h0);
        summarize();
    end
endmodule : overvoltage_protection_stage_tb
